// ---- src/asis_pkg.sv ----
package asis_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] SEL_REG_OFFSET = 12'h040;
    localparam logic [11:0] STATUS_REG_OFFSET = 12'h0F0;
    localparam logic [11:0] COUNT_REG_OFFSET = 12'h0F4;
    localparam logic [31:0] SEL_REG_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_WR_MASK = 32'h7777_7777;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int unsigned NUM_STEPS = 8;
    localparam int unsigned FIELD_W = 3;
    localparam int unsigned FIELD_PITCH = 4;
    localparam int unsigned STEP1_LSB = 0;
    localparam int unsigned STEP6_LSB = 20;
    localparam int unsigned STEP7_LSB = 24;
    localparam int unsigned STEP8_LSB = 28;

    // Status register layout
    localparam int unsigned STAT_CHAN_LSB = 0;
    localparam int unsigned STAT_STEP_LSB = 4;
    localparam int unsigned STAT_VALID_BIT = 8;
    localparam int unsigned STAT_SEEN_BIT = 9;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [7:0] ONEHOT_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [2:0] step;
    } asis_step_s;

    typedef struct packed {
        logic valid;
        logic [2:0] step;
        logic [2:0] chan;
    } asis_sel_s;

endpackage

// ---- src/asis_input_select.sv ----
`timescale 1ns/1ns

// Function
// - During step eight, the topmost field selects the converted input.
// - Field value is the analog input index; value one picks input one.
// - During step six, bits 22 to 20 select the converted input.
// - Bits 31,27,23,19,15,11,7,3 are read-only zero; writes ignored.
// - Selection register is 32 bits, holding eight step selections.
// - During step one, bits 2 to 0 select the converted input.
module asis_input_select #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Sequencer step request
    input wire asis_pkg::asis_step_s step_req,
    // Analog multiplexer selection
    output asis_pkg::asis_sel_s ain_sel,
    output logic [7:0] ain_onehot
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic hit_sel;
    logic hit_stat;
    logic hit_cnt;

    assign hit_sel = (reg_addr == ADDR_W'(asis_pkg::SEL_REG_OFFSET));
    assign hit_stat = (reg_addr == ADDR_W'(asis_pkg::STATUS_REG_OFFSET));
    assign hit_cnt = (reg_addr == ADDR_W'(asis_pkg::COUNT_REG_OFFSET));

    // ------------------------------------------------------------
    // Selection register
    // ------------------------------------------------------------
    logic [31:0] sel_reg_ff;
    logic [31:0] nxt_sel_reg;

    always_comb
    begin
        nxt_sel_reg = sel_reg_ff;
        if (reg_wr && hit_sel)
        begin
            // Reserved lanes are masked off so they can never hold a one
            nxt_sel_reg = reg_wdata & asis_pkg::SEL_WR_MASK;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_reg_ff <= asis_pkg::SEL_REG_RESET;
        end
        else
        begin
            sel_reg_ff <= nxt_sel_reg;
        end
    end

    // ------------------------------------------------------------
    // Channel selection per step
    // ------------------------------------------------------------
    logic [4:0] field_lsb;
    logic [2:0] step_chan;
    asis_pkg::asis_sel_s sel_ff;
    asis_pkg::asis_sel_s nxt_sel;
    logic [7:0] onehot_ff;
    logic [7:0] nxt_onehot;

    // Field n starts at bit 4n; the pitch leaves one reserved bit between fields
    assign field_lsb = {step_req.step, 2'b00};
    // The field is taken from the register before any same-cycle write lands
    assign step_chan = sel_reg_ff[field_lsb +: asis_pkg::FIELD_W];

    always_comb
    begin
        nxt_sel = sel_ff;
        nxt_onehot = onehot_ff;
        nxt_sel.valid = step_req.valid;
        if (step_req.valid)
        begin
            nxt_sel.step = step_req.step;
            nxt_sel.chan = step_chan;
            nxt_onehot = 8'h01 << step_chan;
        end
        else
        begin
            // Mux is released between samples so no input stays connected
            nxt_onehot = asis_pkg::ONEHOT_RESET;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_ff <= '0;
            onehot_ff <= asis_pkg::ONEHOT_RESET;
        end
        else
        begin
            sel_ff <= nxt_sel;
            onehot_ff <= nxt_onehot;
        end
    end

    assign ain_sel = sel_ff;
    assign ain_onehot = onehot_ff;

    // ------------------------------------------------------------
    // Status and sample counter
    // ------------------------------------------------------------
    logic seen_ff;
    logic nxt_seen;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;

    always_comb
    begin
        nxt_seen = seen_ff;
        nxt_cnt = cnt_ff;
        // A write to the counter clears it, but a step in that cycle still counts
        if (reg_wr && hit_cnt)
        begin
            nxt_cnt = asis_pkg::COUNT_RESET;
            nxt_seen = 1'b0;
        end
        if (step_req.valid)
        begin
            nxt_cnt = (reg_wr && hit_cnt) ? 16'h0001 : 16'(cnt_ff + 16'h0001);
            nxt_seen = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seen_ff <= 1'b0;
            cnt_ff <= asis_pkg::COUNT_RESET;
        end
        else
        begin
            seen_ff <= nxt_seen;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] stat_word;

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[asis_pkg::STAT_CHAN_LSB +: 3] = sel_ff.chan;
        stat_word[asis_pkg::STAT_STEP_LSB +: 3] = sel_ff.step;
        stat_word[asis_pkg::STAT_VALID_BIT] = sel_ff.valid;
        stat_word[asis_pkg::STAT_SEEN_BIT] = seen_ff;
    end

    always_comb
    begin
        nxt_rdata = asis_pkg::RD_UNMAPPED;
        if (reg_rd)
        begin
            if (hit_sel)
            begin
                nxt_rdata = sel_reg_ff & asis_pkg::SEL_WR_MASK;
            end
            else if (hit_stat)
            begin
                nxt_rdata = stat_word;
            end
            else if (hit_cnt)
            begin
                nxt_rdata = {16'h0000, cnt_ff};
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_wr_sel;
        reg_wr && hit_sel;
    endsequence

    sequence s_rd_sel;
        reg_rd && hit_sel;
    endsequence

    a_step8_top_field: assert property (
        step_req.valid && step_req.step == 3'h7
        |=> ain_sel.valid && ain_sel.chan == $past(sel_reg_ff[asis_pkg::STEP8_LSB +: 3]))
        else $error("step eight did not use the top field");

    a_chan_onehot_index: assert property (
        ain_sel.valid |-> ain_onehot == (8'h01 << ain_sel.chan))
        else $error("one-hot input does not match selected index");

    a_step6_field: assert property (
        step_req.valid && step_req.step == 3'h5
        |=> ain_sel.chan == $past(sel_reg_ff[asis_pkg::STEP6_LSB +: 3]))
        else $error("step six did not use bits 22 to 20");

    a_resv_read_zero: assert property (
        s_wr_sel ##1 s_rd_sel |=> (reg_rdata & ~asis_pkg::SEL_WR_MASK) == 32'h0000_0000)
        else $error("reserved bits read back nonzero");

    a_wr_rd_round: assert property (
        s_wr_sel ##1 s_rd_sel
        |=> reg_rdata == ($past(reg_wdata, 2) & asis_pkg::SEL_WR_MASK))
        else $error("selection register write did not read back");

    a_step1_field: assert property (
        step_req.valid && step_req.step == 3'h0
        |=> ain_sel.chan == $past(sel_reg_ff[asis_pkg::STEP1_LSB +: 3]))
        else $error("step one did not use bits 2 to 0");

    a_step7_field: assert property (
        step_req.valid && step_req.step == 3'h6
        |=> ain_sel.chan == $past(sel_reg_ff[asis_pkg::STEP7_LSB +: 3]))
        else $error("step seven did not use bits 26 to 24");

    a_idle_release: assert property (
        !step_req.valid |=> !ain_sel.valid && ain_onehot == 8'h00)
        else $error("mux stayed connected without a step");

    a_field_hold: assert property (
        !(reg_wr && hit_sel) |=> $stable(sel_reg_ff))
        else $error("selection register changed without a write");

    a_unmapped_zero: assert property (
        reg_rd && !hit_sel && !hit_stat && !hit_cnt |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");

endmodule

// ---- tb/asis_mux_model.sv ----
`timescale 1ns/1ns

// Analog multiplexer: closes the switch of each pin whose enable is set
module asis_mux_model (
    // Selection from the block
    input wire asis_pkg::asis_sel_s ain_sel,
    input wire logic [7:0] ain_onehot,
    // Observed switch state
    output logic [2:0] pin_idx,
    output logic switch_ok
);
    always_comb
    begin
        pin_idx = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (ain_onehot[i])
            begin
                pin_idx = i[2:0];
            end
        end
        // Two closed switches would short pins together, so demand exactly one while ain_sel.valid is set and none otherwise
        switch_ok = ain_sel.valid ? ($countones(ain_onehot) == 1 && pin_idx === ain_sel.chan)
                                  : (ain_onehot === 8'h00);
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns

module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    asis_pkg::asis_step_s step_req = '0;
    asis_pkg::asis_sel_s ain_sel;
    logic [7:0] ain_onehot;
    logic [2:0] pin_idx;
    logic switch_ok;
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] shadow;
    logic [31:0] rdv;
    localparam logic [11:0] SEL = asis_pkg::SEL_REG_OFFSET;
    localparam logic [11:0] STAT = asis_pkg::STATUS_REG_OFFSET;
    localparam logic [11:0] CNT = asis_pkg::COUNT_REG_OFFSET;

    always #2 mclk = ~mclk;

    asis_input_select dut_u (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .step_req(step_req), .ain_sel(ain_sel), .ain_onehot(ain_onehot));
    asis_mux_model mux_u (.ain_sel(ain_sel), .ain_onehot(ain_onehot), .pin_idx(pin_idx),
        .switch_ok(switch_ok));

    task automatic chk(input logic [31:0] seen, input logic [31:0] expd, input string what);
        comparisons++;
        if (seen !== expd)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s: got %h want %h", $time, what, seen, expd);
        end
    endtask

    function automatic logic [2:0] fld(input logic [31:0] r, input int s);
        return r[4*s +: 3];
    endfunction

    // Status word after the step output has dropped back to idle
    function automatic logic [31:0] stw(input logic [2:0] ch, input logic [2:0] st,
        input logic sn);
        stw = 32'h0000_0000;
        stw[asis_pkg::STAT_CHAN_LSB +: 3] = ch;
        stw[asis_pkg::STAT_STEP_LSB +: 3] = st;
        stw[asis_pkg::STAT_SEEN_BIT] = sn;
    endfunction

    // Each bus task idles one cycle at its end so strobes are never re-driven in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge mclk);
    endtask

    // Write then read with no gap, so the read sees the freshly landed value
    task automatic wrrd(input logic [11:0] a, input logic [31:0] d, output logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge mclk);
    endtask

    task automatic stp(input logic [2:0] s, input logic [2:0] ch);
        step_req <= '{valid: 1'b1, step: s};
        @(posedge mclk);
        step_req.valid <= 1'b0;
        #1;
        chk({25'h0, ain_sel}, {25'h0, 1'b1, s, ch}, "sel");
        chk({24'h0, ain_onehot}, {24'h0, 8'h01 << ch}, "onehot");
        chk({31'h0, switch_ok}, 32'h1, "mux");
        @(posedge mclk);
    endtask

    task automatic conclude;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial
    begin
        #20000;
        num_errors++;
        conclude;
    end

    initial
    begin
        void'($urandom(60384));
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(SEL, rdv);
        chk(rdv, 32'h0000_0000, "reset");
        rd(12'h100, rdv);
        chk(rdv, 32'h0000_0000, "unmapped");
        $display("test reset done");
        wr(SEL, 32'hFFFF_FFFF);
        rd(SEL, rdv);
        chk(rdv, 32'h7777_7777, "reserved set");
        wr(SEL, 32'h8888_8888);
        rd(SEL, rdv);
        chk(rdv, 32'h0000_0000, "reserved only");
        $display("test reserved done");
        wr(SEL, 32'h0000_0001);
        stp(3'h0, 3'h1);
        wr(SEL, 32'h7650_0003);
        stp(3'h7, 3'h7);
        stp(3'h5, 3'h5);
        stp(3'h6, 3'h6);
        stp(3'h0, 3'h3);
        $display("test corner steps done");
        rd(STAT, rdv);
        chk(rdv, stw(3'h3, 3'h0, 1'b1), "status");
        rd(CNT, rdv);
        chk(rdv, 32'h0000_0005, "count");
        // A step in the same cycle as the clear must still be counted
        fork
            wr(CNT, 32'h0000_0000);
            stp(3'h1, 3'h0);
        join
        rd(CNT, rdv);
        chk(rdv, 32'h0000_0001, "count clear and step");
        rd(STAT, rdv);
        chk(rdv, stw(3'h0, 3'h1, 1'b1), "status clear and step");
        wr(CNT, 32'h0000_0000);
        rd(CNT, rdv);
        chk(rdv, 32'h0000_0000, "count clear");
        rd(STAT, rdv);
        chk(rdv, stw(3'h0, 3'h1, 1'b0), "status clear");
        $display("test status and count done");
        repeat (12)
        begin
            // Read-modify-write keeps whatever the reserved bits returned
            rd(SEL, shadow);
            shadow = (shadow & 32'h8888_8888) | ($urandom() & 32'h7777_7777);
            wrrd(SEL, shadow, rdv);
            chk(rdv, shadow & 32'h7777_7777, "readback");
            for (int s = 0; s < 8; s++)
            begin
                stp(s[2:0], fld(shadow, s));
            end
        end
        $display("test random fields done");
        conclude;
    end
endmodule
